// ---- design/spira_slave.sv ----
/*
  spira_slave: documented device end of the serial register-access link.
  Decodes the command word, then hands written words out and takes read
  words in through a user port in the mclk domain.
  Assumes: sclk stands still outside frames and during reset; user side
  answers a read request within about two sclk periods.
*/
// Summary of operation
// [R1] slave only, master supplies serial clock
// [R2] select low starts, high ends transaction
// [R3] all units are 16-bit words
// [R4] first word is command and address
// [R5] command bits 11..2 are address
// [R6] command bit 12: 0 read, 1 write
// [R7] command bit 13: 0 increment, 1 repeat
// [R8] increment address per word unless repeating
// [R9] bits travel most significant first
// [R10] output bit changes on falling edge
// [R11] input sampled on rising edge
// [R12] write data follows command without gap
// [R13] read data starts right after command
// [R14] master ends burst by raising select
// [R15] master clock at most 16 MHz
// [R16] output released while not selected
// [R17] poll status with repeating burst
// [R18] partial word on deselect is dropped
// [R19] each select fall restarts decoding
`timescale 1ns/1ps
module spira_slave (
  input wire logic mclk_i,                  // system clock
  input wire logic rst_i,                   // reset, active high; synchronous in the mclk domain, asynchronous in the sclk domain
  spira_if.slave link,                      // serial link
  output logic wr_valid_o,                  // one written word ready
  output logic [9:0] wr_addr_o,             // register address of write
  output logic [15:0] wr_data_o,            // written data
  input wire logic wr_ready_i,              // user takes written word
  output logic rd_req_o,                    // one-cycle read request
  output logic [9:0] rd_addr_o,             // register address of read
  input wire logic [15:0] rd_data_i,        // read data, valid with rd_ack_i
  input wire logic rd_ack_i                 // read data strobe
);
  // ----------------------------------------------------------------
  // sclk domain: shift, count and decode
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt_ff;
  logic [14:0] shift_ff;
  logic cmd_done_ff;
  logic dir_wr_ff;
  logic repeat_ff;
  logic [9:0] addr_ff;
  logic [15:0] cap_word_ff;
  logic [9:0] cap_addr_ff;
  logic wr_tog_ff;
  logic rd_tog_ff;
  logic [9:0] rd_addr_s_ff;
  logic [15:0] word_in;
  logic [9:0] nxt_addr;
  logic [15:0] tx_sel;
  logic [15:0] tx_ff;
  logic [15:0] rd_hold_ff;

  assign word_in = {shift_ff, link.serial_in}; // [R9]
  assign nxt_addr = word_in[spira_pkg::CMD_ADDR_MSB:spira_pkg::CMD_ADDR_LSB]; // [R5]

  // select high acts as async clear so each frame decodes afresh; the
  // link clock is still while select is high, so nothing else can act
  always_ff @(posedge link.sclk or posedge link.select_n) begin
    if (link.select_n) begin // [R2] [R19]
      bit_cnt_ff <= 4'h0;
      shift_ff <= 15'h0000;
      cmd_done_ff <= 1'b0;
      dir_wr_ff <= 1'b0;
      repeat_ff <= 1'b0;
      addr_ff <= 10'h000;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1; // [R3]
      shift_ff <= word_in[14:0]; // [R11]
      if (bit_cnt_ff == spira_pkg::CNT_LAST) begin
        if (!cmd_done_ff) begin // [R4]
          cmd_done_ff <= 1'b1;
          dir_wr_ff <= word_in[spira_pkg::CMD_DIR_BIT]; // [R6]
          repeat_ff <= word_in[spira_pkg::CMD_BURST_BIT]; // [R7]
          addr_ff <= nxt_addr;
        end else if (!repeat_ff) begin
          addr_ff <= addr_ff + 10'h001; // [R8]
        end
      end
    end
  end

  // capture completed words; a partial word never toggles, so it is lost.
  // toggles start from a known level: reset while the link clock is idle
  always_ff @(posedge link.sclk or posedge rst_i) begin
    if (rst_i) begin
      cap_word_ff <= spira_pkg::RST_WORD;
      cap_addr_ff <= 10'h000;
      wr_tog_ff <= 1'b0;
      rd_addr_s_ff <= 10'h000;
      rd_tog_ff <= 1'b0;
    end else if (!link.select_n) begin
      if (bit_cnt_ff == spira_pkg::CNT_LAST && cmd_done_ff && dir_wr_ff) begin // [R12] [R18]
        cap_word_ff <= word_in;
        cap_addr_ff <= addr_ff;
        wr_tog_ff <= ~wr_tog_ff;
      end
      // fetch the next read word two and a half link periods before it must go out,
      // so the mclk side has time to cross, answer and settle the hold reg
      if (bit_cnt_ff == spira_pkg::CNT_FETCH) begin
        if (!cmd_done_ff && !word_in[spira_pkg::CMD_DIR_BIT - spira_pkg::CMD_ADDR_LSB]) begin
          rd_addr_s_ff <= word_in[spira_pkg::ADDR_W-1:0]; // [R5]
          rd_tog_ff <= ~rd_tog_ff;
        end else if (cmd_done_ff && !dir_wr_ff) begin
          rd_addr_s_ff <= repeat_ff ? addr_ff : addr_ff + 10'h001; // [R8]
          rd_tog_ff <= ~rd_tog_ff;
        end
      end
    end
  end

  // hold register was filled by the early fetch and is stable at the load
  assign tx_sel = rd_hold_ff;

  // output shifts on falling edge, first bit right after the command
  always_ff @(negedge link.sclk or posedge link.select_n) begin
    if (link.select_n) begin
      tx_ff <= 16'h0000;
    end else if (bit_cnt_ff == 4'h0 && cmd_done_ff && !dir_wr_ff) begin
      tx_ff <= tx_sel; // [R13]
    end else begin
      tx_ff <= {tx_ff[14:0], 1'b0}; // [R10] [R9]
    end
  end
  assign link.serial_out = tx_ff[15];
  assign link.serial_out_oe = ~link.select_n; // [R16] [R1]

  // ----------------------------------------------------------------
  // crossing into mclk: toggles through two flops, words held stable
  // ----------------------------------------------------------------
  logic [2:0] wr_sync_ff;
  logic [2:0] rd_sync_ff;
  logic [15:0] buf_data_ff [2];
  logic [9:0] buf_addr_ff [2];
  logic [1:0] buf_cnt_ff;
  logic buf_wp_ff;
  logic buf_rp_ff;
  logic push;
  logic pop;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
    end else begin
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tog_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_tog_ff};
    end
  end
  assign push = wr_sync_ff[2] ^ wr_sync_ff[1];
  assign pop = wr_valid_o && wr_ready_i;

  // two-entry buffer; while a stalled user leaves both entries full, further written words are dropped
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      buf_cnt_ff <= 2'h0;
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
    end else begin
      if (push && buf_cnt_ff != 2'h2) begin
        buf_data_ff[buf_wp_ff] <= cap_word_ff;
        buf_addr_ff[buf_wp_ff] <= cap_addr_ff;
        buf_wp_ff <= ~buf_wp_ff;
      end
      if (pop) begin
        buf_rp_ff <= ~buf_rp_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push && buf_cnt_ff != 2'h2} - {1'b0, pop};
    end
  end

  // user side outputs straight from flops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_addr_o <= 10'h000;
      wr_data_o <= spira_pkg::RST_WORD;
      rd_req_o <= 1'b0;
      rd_addr_o <= 10'h000;
      rd_hold_ff <= spira_pkg::RST_WORD;
    end else begin
      if (!wr_valid_o || pop) begin
        wr_valid_o <= (buf_cnt_ff - {1'b0, pop}) != 2'h0;
        wr_data_o <= buf_data_ff[buf_rp_ff ^ pop];
        wr_addr_o <= buf_addr_ff[buf_rp_ff ^ pop];
      end
      rd_req_o <= rd_sync_ff[2] ^ rd_sync_ff[1];
      if (rd_sync_ff[2] ^ rd_sync_ff[1]) begin
        rd_addr_o <= rd_addr_s_ff;
      end
      if (rd_ack_i) begin
        rd_hold_ff <= rd_data_i;
      end
    end
  end
endmodule : spira_slave

// ---- design/spira_pkg.sv ----
/*
  spira_pkg: shared constants for the serial register-access link
  (command word layout, word size, link timing).
  Assumes: both link ends and the bench refer to these by full name.
*/
package spira_pkg;
  // ----------------------------------------------------------------
  // word and command layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ADDR_W = 10;
  localparam int CMD_DIR_BIT = 12;
  localparam int CMD_BURST_BIT = 13;
  localparam int CMD_ADDR_MSB = 11;
  localparam int CMD_ADDR_LSB = 2;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;
  // bit count at which the next read word is fetched (14th bit sampled)
  localparam logic [CNT_W-1:0] CNT_FETCH = 4'hD;
  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int MCLK_MHZ = 100;
  localparam int SCK_MAX_MHZ = 16;
  // half period in mclk cycles, rounded up so the link stays at or below 16 MHz
  localparam int SCK_HALF = (MCLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int HCNT_W = 4;
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
endpackage : spira_pkg

// ---- design/spira_if.sv ----
/*
  spira_if: the four-wire serial link between master and slave.
  Assumes: the bench joins master and slave modules through it.
*/
`timescale 1ns/1ps
interface spira_if;
  logic sclk;         // serial clock, master drives
  logic select_n;     // chip select, active low
  logic serial_in;    // master to slave data
  logic serial_out;   // slave to master data
  logic serial_out_oe; // slave drives serial_out while high

  modport master (
    output sclk,
    output select_n,
    output serial_in,
    input serial_out,
    input serial_out_oe
  );
  modport slave (
    input sclk,
    input select_n,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );
endinterface : spira_if

// ---- design/spira_master.sv ----
/*
  spira_master: far end of the serial register-access link.
  Runs one transaction per start pulse: command word, then a given
  number of data words, with the link clock divided from mclk.
  Assumes: write words arrive through wdata valid/ready while busy.
*/
`timescale 1ns/1ps
module spira_master (
  input wire logic mclk_i,              // system clock
  input wire logic rst_i,               // synchronous reset, active high
  spira_if.master link,                 // serial link
  input wire logic start_i,             // one-cycle start pulse
  input wire logic wr_i,                // 1 write, 0 read
  input wire logic repeat_i,            // 1 repeating burst
  input wire logic [9:0] addr_i,        // start register address
  input wire logic [7:0] words_i,       // data words, at least 1
  input wire logic wdata_valid_i,       // write word offered
  input wire logic [15:0] wdata_i,      // write word
  output logic wdata_ready_o,           // write word taken
  output logic rdata_valid_o,           // one-cycle read word strobe
  output logic [15:0] rdata_o,          // read word
  output logic busy_o                   // transaction in progress
);
  typedef enum logic [1:0] {
    SPIRAM_IDLE = 2'b00,
    SPIRAM_LOAD = 2'b01,
    SPIRAM_SHIFT = 2'b11,
    SPIRAM_END = 2'b10
  } spiram_state_t;

  spiram_state_t state_ff;
  logic [3:0] half_ff;
  logic [3:0] bit_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic [7:0] left_ff;
  logic first_ff;
  logic wr_ff;
  logic in_s1_ff;
  logic in_s2_ff;
  logic half_done;

  assign half_done = half_ff == 4'(spira_pkg::SCK_HALF - 1); // [R15]

  // serial_out returns through two flops; half period of 4 mclk cycles covers it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      in_s1_ff <= 1'b0;
      in_s2_ff <= 1'b0;
    end else begin
      in_s1_ff <= link.serial_out;
      in_s2_ff <= in_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= SPIRAM_IDLE;
      half_ff <= 4'h0;
      bit_ff <= 4'h0;
      tx_ff <= spira_pkg::RST_WORD;
      rx_ff <= spira_pkg::RST_WORD;
      left_ff <= 8'h00;
      first_ff <= 1'b0;
      wr_ff <= 1'b0;
      link.sclk <= 1'b0;
      link.select_n <= 1'b1;
      link.serial_in <= 1'b0;
      wdata_ready_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o <= spira_pkg::RST_WORD;
      busy_o <= 1'b0;
    end else begin
      wdata_ready_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      case (state_ff)
        SPIRAM_IDLE: begin
          if (start_i) begin
            // command word: bit 13 burst, bit 12 direction, 11..2 address
            tx_ff <= {2'b00, repeat_i, wr_i, addr_i, 2'b00}; // [R4] [R5] [R6] [R7]
            wr_ff <= wr_i;
            left_ff <= words_i;
            first_ff <= 1'b1;
            busy_o <= 1'b1;
            link.select_n <= 1'b0; // [R2]
            state_ff <= SPIRAM_LOAD;
          end
        end
        SPIRAM_LOAD: begin
          link.serial_in <= tx_ff[15]; // [R9]
          bit_ff <= 4'h0;
          half_ff <= 4'h0;
          state_ff <= SPIRAM_SHIFT;
        end
        SPIRAM_SHIFT: begin
          half_ff <= half_done ? 4'h0 : half_ff + 4'h1;
          if (half_done) begin
            link.sclk <= ~link.sclk; // [R1]
            if (!link.sclk) begin
              rx_ff <= {rx_ff[14:0], in_s2_ff};
            end else begin
              // falling edge: present next bit so it is valid at the rise
              bit_ff <= bit_ff + 4'h1;
              tx_ff <= {tx_ff[14:0], 1'b0};
              link.serial_in <= tx_ff[14]; // [R11]
              if (bit_ff == spira_pkg::CNT_LAST) begin
                first_ff <= 1'b0;
                if (!first_ff) begin
                  left_ff <= left_ff - 8'h01;
                  rdata_valid_o <= !wr_ff;
                  rdata_o <= rx_ff;
                end
                if (!first_ff && left_ff == 8'h01) begin
                  state_ff <= SPIRAM_END; // [R14]
                end else if (wr_ff) begin
                  // data follows the command with no gap word
                  tx_ff <= wdata_i; // [R12]
                  link.serial_in <= wdata_i[15];
                  wdata_ready_o <= 1'b1;
                end
              end
            end
          end
        end
        SPIRAM_END: begin
          link.select_n <= 1'b1;
          busy_o <= 1'b0;
          state_ff <= SPIRAM_IDLE;
        end
        default: state_ff <= SPIRAM_IDLE;
      endcase
    end
  end
  // rx sampling uses the synchronised copy, so a read needs a slow enough
  // link; the divider keeps SCK_HALF at 4 mclk cycles minimum for 100 MHz
endmodule : spira_master

// ---- sim/spira_asserts.sv ----
/* spira_asserts: timing and framing checks on the serial link wires.
   Assumes: instantiated by the bench beside the link, sampled on mclk. */
`timescale 1ns/1ps
module spira_asserts (
  input wire logic mclk_i,       // system clock
  input wire logic rst_i,        // synchronous reset
  input wire logic sclk,         // link clock
  input wire logic select_n,     // chip select, active low
  input wire logic serial_in,    // master data
  input wire logic serial_out,   // slave data
  input wire logic serial_out_oe // slave drive enable
);
  // ----------------------------------------
  // helper: rising link edges in this frame
  // ----------------------------------------
  logic sclk_d_ff;
  logic [11:0] rises_ff;
  // counted on mclk so frame length is judged at deselect
  always_ff @(posedge mclk_i) begin
    sclk_d_ff <= sclk;
    if (rst_i || select_n) rises_ff <= 12'h000;
    else if (sclk && !sclk_d_ff) rises_ff <= rises_ff + 12'h001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_oe_sel; $stable(select_n) |-> (serial_out_oe == !select_n); endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output drive not tied to select");
  property p_idle_clk; select_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("link clock moves while idle");
  property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("link clock high phase wrong");
  property p_low; $fell(sclk) |-> !sclk [*4]; endproperty
  a_low: assert property (p_low) else $error("link clock low phase too short");
  property p_out_fall;
    (!select_n && $past(!select_n) && $changed(serial_out)) |-> $fell(sclk);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("slave data moved off falling edge");
  property p_in_stable; $rose(sclk) |-> $stable(serial_in) ##1 $stable(serial_in); endproperty
  a_in_stable: assert property (p_in_stable) else $error("master data moved at rise");
  property p_words;
    $rose(select_n) |-> (rises_ff[3:0] == 4'h0) && (rises_ff >= 12'h020);
  endproperty
  a_words: assert property (p_words) else $error("frame not whole words");
  property p_start; $fell(select_n) |-> !sclk [*2]; endproperty
  a_start: assert property (p_start) else $error("clock too soon after select");
endmodule : spira_asserts

// ---- sim/testbench.sv ----
/* testbench: master and slave joined by the link, plus a second slave
   driven bit by bit at a 48 ns link clock for malformed frames.
   Assumes: design files compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0, wr_i = 1'b0, repeat_i = 1'b0, wdata_valid_i = 1'b0;
  logic rd_ack_i = 1'b0, wr_ready_i = 1'b1, stall = 1'b0;
  logic [9:0] addr_i = 10'h000;
  logic [7:0] words_i = 8'h01;
  logic [15:0] wdata_i = 16'h0000, rd_data_i = 16'h0000, sh, so_sh, exp_first;
  logic wdata_ready_o, rdata_valid_o, busy_o, wr_valid_o, rd_req_o, s2_valid;
  logic [15:0] rdata_o, wr_data_o, s2_data;
  logic [9:0] wr_addr_o, rd_addr_o, s2_addr;
  logic [11:0] exp_cmd;
  logic [15:0] mem [1024];
  logic [15:0] wq[$], eq_d[$], rq[$];
  logic [9:0] eq_a[$];
  logic [9:0] e2a [3];
  logic [15:0] e2d [3];
  int mismatches = 0, num_checks = 0, cycles = 0, bitn = 0, s2_n = 0;
  spira_if lnk();
  spira_if lnk2();
  spira_master spira_master_inst (.mclk_i(mclk_i), .rst_i(rst_i), .link(lnk),
    .start_i(start_i), .wr_i(wr_i), .repeat_i(repeat_i), .addr_i(addr_i),
    .words_i(words_i), .wdata_valid_i(wdata_valid_i), .wdata_i(wdata_i),
    .wdata_ready_o(wdata_ready_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
    .busy_o(busy_o));
  spira_slave spira_slave_inst (.mclk_i(mclk_i), .rst_i(rst_i), .link(lnk),
    .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_ready_i(wr_ready_i), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .rd_ack_i(rd_ack_i));
  // second slave: its read side is tied off, only writes are sent to it
  spira_slave spira_slave2_inst (.mclk_i(mclk_i), .rst_i(rst_i), .link(lnk2),
    .wr_valid_o(s2_valid), .wr_addr_o(s2_addr), .wr_data_o(s2_data),
    .wr_ready_i(1'b1), .rd_req_o(), .rd_addr_o(), .rd_data_i(16'h0000), .rd_ack_i(1'b0));
  spira_asserts spira_asserts_inst (.mclk_i(mclk_i), .rst_i(rst_i), .sclk(lnk.sclk),
    .select_n(lnk.select_n), .serial_in(lnk.serial_in), .serial_out(lnk.serial_out),
    .serial_out_oe(lnk.serial_out_oe));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  function automatic logic [9:0] exp_addr(logic [9:0] a, logic r, int k);
    return r ? a : a + 10'(k);
  endfunction : exp_addr
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // user side: feed write words, answer read requests within a cycle
  always @(posedge mclk_i) begin
    if (wdata_ready_o === 1'b1 && wdata_valid_i === 1'b1) void'(wq.pop_front());
    #1;
    wdata_valid_i = (wq.size() > 0);
    if (wq.size() > 0) wdata_i = wq[0];
    wr_ready_i = !stall && ($urandom % 4 != 0);
    rd_ack_i = (rd_req_o === 1'b1);
    if (rd_req_o === 1'b1) rd_data_i = mem[rd_addr_o];
  end
  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
      if (eq_a.size() == 0) `CHK("wr_extra", 1'b0, 1'b1)
      else begin
        `CHK("wr_addr", eq_a.pop_front(), wr_addr_o)
        `CHK("wr_data", eq_d.pop_front(), wr_data_o)
        mem[wr_addr_o] = wr_data_o;
      end
    end
    if (rdata_valid_o === 1'b1) begin
      if (rq.size() == 0) `CHK("rd_extra", 1'b0, 1'b1)
      else `CHK("rd_data", rq.pop_front(), rdata_o)
    end
    if (s2_valid === 1'b1) begin
      `CHK("s2_addr", e2a[s2_n % 3], s2_addr)
      `CHK("s2_data", e2d[s2_n % 3], s2_data)
      s2_n++;
    end
  end
  // wire view: command layout, bit order and first read word
  always @(negedge lnk.select_n) bitn = 0;
  always @(posedge lnk.sclk) begin
    sh = {sh[14:0], lnk.serial_in};
    so_sh = {so_sh[14:0], lnk.serial_out};
    bitn++;
    if (bitn == 16) `CHK("cmd_word", exp_cmd, sh[13:2])
    if (bitn == 32 && exp_cmd[10] == 1'b0) `CHK("rd_wire", exp_first, so_sh)
  end
  task automatic xact(input logic w, input logic r, input logic [9:0] a, input int n);
    logic [15:0] d;
    int k;
    exp_cmd = {r, w, a};
    for (k = 0; k < n; k++) begin
      d = 16'($urandom);
      if (w) begin
        wq.push_back(d);
        eq_a.push_back(exp_addr(a, r, k));
        eq_d.push_back(d);
      end else begin
        rq.push_back(mem[exp_addr(a, r, k)]);
        if (k == 0) exp_first = mem[a];
      end
    end
    @(posedge mclk_i);
    #1;
    {wr_i, repeat_i, addr_i, words_i, start_i} = {w, r, a, 8'(n), 1'b1};
    @(posedge mclk_i);
    #1;
    start_i = 1'b0;
    k = 0;
    while (busy_o !== 1'b0 && k < 5000) begin
      @(posedge mclk_i);
      k++;
    end
    stall = 1'b0;
    repeat (20) @(posedge mclk_i);
    `CHK("words_left", 0, eq_a.size() + rq.size())
  endtask : xact
  // bit-banged link for the second slave, 48 ns clock only inside frames
  task automatic bang(input logic [15:0] w, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      lnk2.serial_in = w[15-i];
      #24 lnk2.sclk = 1'b1;
      #24 lnk2.sclk = 1'b0;
    end
  endtask : bang
  initial begin
    void'($urandom(93507));
    foreach (mem[i]) mem[i] = 16'($urandom);
    {lnk2.sclk, lnk2.select_n, lnk2.serial_in} = 3'b010;
    repeat (3) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    xact(1'b1, 1'b0, 10'h3FE, 2); // top of address space
    xact(1'b0, 1'b0, 10'h3FE, 2);
    xact(1'b0, 1'b1, 10'h3FF, 3); // status polling
    stall = 1'b1;
    xact(1'b1, 1'b0, 10'h010, 2); // user stalls, buffer holds both
    repeat (12) xact(1'($urandom), 1'($urandom), 10'($urandom % 1000), 1 + $urandom % 4);
    e2a = '{10'h155, 10'h2AA, 10'h2AA};
    e2d = '{16'hC3A5, 16'h0F0F, 16'hF00D};
    // ignored command bits set, then a partial word before deselect
    lnk2.select_n = 1'b0;
    #30 bang({4'hD, e2a[0], 2'b11}, 16);
    bang(e2d[0], 16);
    bang(16'hFFFF, 7);
    #30 lnk2.select_n = 1'b1;
    lnk2.serial_in = ~lnk2.serial_in;
    #400 lnk2.select_n = 1'b0;
    #30 bang({4'h3, e2a[1], 2'b00}, 16);
    bang(e2d[1], 16);
    bang(e2d[2], 16);
    #30 lnk2.select_n = 1'b1;
    repeat (30) @(posedge mclk_i);
    `CHK("s2_count", 3, s2_n)
    end_sim();
  end
endmodule : testbench
